// ---- srm_regs.svh ----
// status register model: offsets, widths, reset values
// assumes inclusion by bare name from the design files
`ifndef SRM_REGS_SVH
`define SRM_REGS_SVH

`define SRM_NSETS       2
`define SRM_W16         16
`define SRM_W8          8
`define SRM_MSB16       15
`define SRM_ENA_RST16   16'h0000
`define SRM_EVT_RST16   16'h0000
`define SRM_ENA_RST8    8'h00
`define SRM_EVT_RST8    8'h00
`define SRM_SEL_STB     3'h0
`define SRM_SEL_SRE     3'h1
`define SRM_SEL_ESR     3'h2
`define SRM_SEL_ESE     3'h3
`define SRM_SEL_COND    3'h4
`define SRM_SEL_EVT     3'h5
`define SRM_SEL_ENA     3'h6
`define SRM_BIT_SUM0    3
`define SRM_BIT_MAV     4
`define SRM_BIT_ESB     5
`define SRM_BIT_RQS     6
`define SRM_BIT_SUM1    7
`define SRM_STB_USED    8'hB8
`define SRM_SRE_MASK    8'hBF

`endif

// ---- srm_pkg.sv ----
// status register model: shared types
// no assumptions beyond the header
`default_nettype none

package srm_pkg;
  typedef enum logic [1:0]
  {
    SRM_IDLE    = 2'b00,
    SRM_PENDING = 2'b01
  } srm_srq_t;
endpackage

`default_nettype wire

// ---- srm_set16.sv ----
// one 16-bit status register set: condition, event, enable, summary
// assumes conditions synchronous to ref_clk_i
`timescale 1ns/100ps
`default_nettype none
`include "srm_regs.svh"

module srm_set16
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] cond_i,
  input  wire logic        evt_rd_i,
  input  wire logic        clear_i,
  input  wire logic        ena_wr_i,
  input  wire logic [15:0] ena_wdata_i,
  output logic      [15:0] cond_o,
  output logic      [15:0] evt_o,
  output logic      [15:0] ena_o,
  output logic             sum_o
);
  typedef struct packed
  {
    logic [15:0] cond;
    logic [15:0] evt;
    logic [15:0] ena;
  } srm_s16_t;

  srm_s16_t st;
  srm_s16_t next_st;
  logic [15:0] live;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    live = cond_i & ~(16'h0001 << `SRM_MSB16);
    next_st = st;
    next_st.cond = live;
    if (clear_i || evt_rd_i)
    begin
      next_st.evt = `SRM_EVT_RST16;
    end
    next_st.evt = next_st.evt | (st.evt & ~{16{clear_i | evt_rd_i}})
                  | (live ^ st.cond);
    if (ena_wr_i)
    begin
      next_st.ena = ena_wdata_i & ~(16'h0001 << `SRM_MSB16);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '{cond: 16'h0000, evt: `SRM_EVT_RST16, ena: `SRM_ENA_RST16};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign cond_o = st.cond;
  assign evt_o  = st.evt;
  assign ena_o  = st.ena;
  assign sum_o  = |(st.evt & st.ena);

  evt_sticky_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (st.evt != 16'h0000) && !clear_i && !evt_rd_i
      |=> ((st.evt & $past(st.evt)) == $past(st.evt)))
    else $error("event bit dropped without clear");
  msb_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !st.evt[15] && !st.ena[15] && !st.cond[15])
    else $error("bit 15 not zero");
  change_sets_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((cond_i[14:0] ^ st.cond[14:0]) != 15'h0000) |=>
      ((st.evt[14:0] & $past(cond_i[14:0] ^ st.cond[14:0]))
        == $past(cond_i[14:0] ^ st.cond[14:0])))
    else $error("condition change not latched");
endmodule

`default_nettype wire

// ---- srm_top.sv ----
// status register model top: status byte, standard event, 16-bit sets
// Operation
// - status byte and standard event are 8 bits; other sets 16 bits
// - bit 15 of each 16-bit register always zero
// - condition bits follow live conditions without latching
// - condition registers are read-only; writes ignored
// - any condition bit change sets its event bit
// - set event bits stay set until cleared
// - reading an event register returns contents then clears it
// - clear-status command clears all event registers together
// - event registers not writable; only condition changes set them, except the standard event register, set by std_evt_set_i
// - summary bit is OR of event bits ANDed with enables
// - enable registers read and write; read returns last write, except request enable bit 6 and 16-bit enable bit 15 read zero
// - service request raised unprompted when enabled summary rises from 0 to 1
// - unassigned status bits always read as zero
// - serial poll clears request-service bit, other bits untouched
// assumes one clock; commands arrive as one-cycle strobes
`timescale 1ns/100ps
`default_nettype none
`include "srm_regs.svh"

module srm_top
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] cond_i,
  input  wire logic [7:0]  std_evt_set_i,
  input  wire logic        msg_avail_i,
  input  wire logic        rd_i,
  input  wire logic [2:0]  rd_sel_i,
  input  wire logic        rd_set_i,
  input  wire logic        wr_i,
  input  wire logic [2:0]  wr_sel_i,
  input  wire logic        wr_set_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        clear_status_i,
  input  wire logic        serial_poll_i,
  output logic      [15:0] rd_data_o,
  output logic             srq_o
);
  typedef struct packed
  {
    logic [7:0]       esr;
    logic [7:0]       ese;
    logic [7:0]       sre;
    logic             rqs;
    srm_pkg::srm_srq_t srq;
    logic             mss_q;
    logic [15:0]      rdata;
  } srm_top_t;

  srm_top_t st;
  srm_top_t next_st;
  logic [1:0]  sum16;
  logic [15:0] cond_v [2];
  logic [15:0] evt_v  [2];
  logic [15:0] ena_v  [2];
  logic [1:0]  evt_rd;
  logic [1:0]  ena_wr;
  logic [7:0]  stb;
  logic        mss;

  ////////////////////////////////////////////////////////////////////////
  // 16-bit register sets
  genvar g;
  generate
    for (g = 0; g < `SRM_NSETS; g++)
    begin : g_set
      assign evt_rd[g] = rd_i && rd_sel_i == `SRM_SEL_EVT && rd_set_i == 1'(g);
      assign ena_wr[g] = wr_i && wr_sel_i == `SRM_SEL_ENA && wr_set_i == 1'(g);
      srm_set16 u_set
      (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .cond_i      (cond_i[16*g +: 16]),
        .evt_rd_i    (evt_rd[g]),
        .clear_i     (clear_status_i),
        .ena_wr_i    (ena_wr[g]),
        .ena_wdata_i (wr_data_i),
        .cond_o      (cond_v[g]),
        .evt_o       (evt_v[g]),
        .ena_o       (ena_v[g]),
        .sum_o       (sum16[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // status byte: condition-like, bit 6 from mss or rqs
  always_comb
  begin
    stb = 8'h00;
    stb[`SRM_BIT_SUM0] = sum16[0];
    stb[`SRM_BIT_MAV]  = msg_avail_i;
    stb[`SRM_BIT_ESB]  = |(st.esr & st.ese);
    stb[`SRM_BIT_SUM1] = sum16[1];
  end
  assign mss = |(stb & st.sre & `SRM_SRE_MASK);

  always_comb
  begin
    next_st = st;
    next_st.mss_q = mss;
    if (clear_status_i || (rd_i && rd_sel_i == `SRM_SEL_ESR))
    begin
      next_st.esr = `SRM_EVT_RST8;
    end
    next_st.esr = next_st.esr | std_evt_set_i;
    if (wr_i && wr_sel_i == `SRM_SEL_ESE)
    begin
      next_st.ese = wr_data_i[7:0];
    end
    if (wr_i && wr_sel_i == `SRM_SEL_SRE)
    begin
      next_st.sre = wr_data_i[7:0] & `SRM_SRE_MASK;
    end
    unique case (st.srq)
      srm_pkg::SRM_IDLE:
      begin
        if (mss && !st.mss_q)
        begin
          next_st.srq = srm_pkg::SRM_PENDING;
          next_st.rqs = 1'b1;
        end
      end
      srm_pkg::SRM_PENDING:
      begin
        if (serial_poll_i)
        begin
          next_st.srq = srm_pkg::SRM_IDLE;
          next_st.rqs = 1'b0;
        end
      end
      default:
      begin
        next_st.srq = srm_pkg::SRM_IDLE;
        next_st.rqs = 1'b0;
      end
    endcase
    if (serial_poll_i)
    begin
      next_st.rdata = {8'h00, stb};
      next_st.rdata[`SRM_BIT_RQS] = st.rqs;
    end
    else if (rd_i)
    begin
      unique case (rd_sel_i)
        `SRM_SEL_STB:  next_st.rdata = {8'h00, stb | {1'b0, mss, 6'h00}};
        `SRM_SEL_SRE:  next_st.rdata = {8'h00, st.sre};
        `SRM_SEL_ESR:  next_st.rdata = {8'h00, st.esr};
        `SRM_SEL_ESE:  next_st.rdata = {8'h00, st.ese};
        `SRM_SEL_COND: next_st.rdata = cond_v[rd_set_i];
        `SRM_SEL_EVT:  next_st.rdata = evt_v[rd_set_i];
        `SRM_SEL_ENA:  next_st.rdata = ena_v[rd_set_i];
        default:       next_st.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '{esr: `SRM_EVT_RST8, ese: `SRM_ENA_RST8, sre: `SRM_ENA_RST8, rqs: 1'b0,
              srq: srm_pkg::SRM_IDLE, mss_q: 1'b0, rdata: 16'h0000};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rd_data_o = st.rdata;
  assign srq_o     = st.rqs;

  ////////////////////////////////////////////////////////////////////////
  srq_raise_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    st.srq == srm_pkg::SRM_IDLE && mss && !st.mss_q |=> srq_o)
    else $error("service request not raised");
  poll_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    serial_poll_i |=> !srq_o)
    else $error("serial poll left request set");
  poll_data_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    serial_poll_i |=> rd_data_o[`SRM_BIT_RQS] == $past(st.rqs)
      && rd_data_o[15:8] == 8'h00)
    else $error("serial poll data wrong");
  cls_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    clear_status_i && std_evt_set_i == 8'h00 |=> st.esr == 8'h00)
    else $error("clear status left standard events");
  esr_sticky_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !clear_status_i && !(rd_i && rd_sel_i == `SRM_SEL_ESR)
      |=> (st.esr & $past(st.esr)) == $past(st.esr))
    else $error("standard event bit dropped");
  esr_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rd_i && !serial_poll_i && rd_sel_i == `SRM_SEL_ESR
      |=> rd_data_o[7:0] == $past(st.esr) && st.esr == $past(std_evt_set_i))
    else $error("standard event read wrong");
  sre_wr_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_i && wr_sel_i == `SRM_SEL_SRE |=> st.sre == ($past(wr_data_i[7:0]) & 8'hBF))
    else $error("enable write lost");
  ese_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rd_i && !serial_poll_i && rd_sel_i == `SRM_SEL_ESE
      |=> rd_data_o[7:0] == $past(st.ese))
    else $error("enable read wrong");
  byte_width_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rd_i && !serial_poll_i && rd_sel_i < `SRM_SEL_COND |=> rd_data_o[15:8] == 8'h00)
    else $error("byte register upper half nonzero");
  sre_bit6_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !st.sre[`SRM_BIT_RQS])
    else $error("request enable bit 6 set");
  esb_sum_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rd_i && !serial_poll_i && rd_sel_i == `SRM_SEL_STB
      |=> rd_data_o[`SRM_BIT_ESB] == ($past(st.esr & st.ese) != 8'h00))
    else $error("summary bit wrong");
  unused_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $past(rd_i) && !$past(serial_poll_i) && $past(rd_sel_i) == `SRM_SEL_STB
      |-> rd_data_o[2:0] == 3'h0)
    else $error("unused status bits nonzero");
endmodule

`default_nettype wire

// ---- srm_ctrl_model.sv ----
// controller model: read, write, serial poll and clear-status strobes
// assumes the device takes strobes on rising edges of ref_clk_i
`timescale 1ns/100ps
`default_nettype none

module srm_ctrl_model
(
  input  wire logic        ref_clk_i,
  input  wire logic [15:0] data_i,
  output logic             rd_o = 1'h0,
  output logic      [2:0]  rsel_o = 3'h0,
  output logic             rset_o = 1'h0,
  output logic             wr_o = 1'h0,
  output logic      [2:0]  wsel_o = 3'h0,
  output logic             wset_o = 1'h0,
  output logic      [15:0] wdata_o = 16'h0000,
  output logic             cls_o = 1'h0,
  output logic             poll_o = 1'h0
);
  ////////////////////////////////////////////////////////////////
  // select a register, query it, return the answer
  task automatic rd(input logic [2:0] s, input logic t, output logic [15:0] d);
    @(posedge ref_clk_i);
    rd_o <= 1'h1;
    rsel_o <= s;
    rset_o <= t;
    @(posedge ref_clk_i);
    rd_o <= 1'h0;
    @(posedge ref_clk_i);
    d = data_i;
  endtask

  task automatic wr(input logic [2:0] s, input logic t, input logic [15:0] v);
    @(posedge ref_clk_i);
    wr_o <= 1'h1;
    wsel_o <= s;
    wset_o <= t;
    wdata_o <= v;
    @(posedge ref_clk_i);
    wr_o <= 1'h0;
  endtask

  task automatic poll(output logic [15:0] d);
    @(posedge ref_clk_i);
    poll_o <= 1'h1;
    @(posedge ref_clk_i);
    poll_o <= 1'h0;
    @(posedge ref_clk_i);
    d = data_i;
  endtask

  task automatic cls();
    @(posedge ref_clk_i);
    cls_o <= 1'h1;
    @(posedge ref_clk_i);
    cls_o <= 1'h0;
  endtask
endmodule

`default_nettype wire

// ---- status_register_model_test.sv ----
// testbench: table of condition steps, then hand-written cases
// assumes srm_top and srm_ctrl_model compiled alongside
`timescale 1ns/100ps
`default_nettype none

module status_register_model_test;
  logic        ref_clk_i;
  logic        rst_i;
  logic [31:0] cond_i;
  logic [7:0]  std_evt_set_i;
  logic        msg_avail_i;
  logic        rd_i;
  logic [2:0]  rd_sel_i;
  logic        rd_set_i;
  logic        wr_i;
  logic [2:0]  wr_sel_i;
  logic        wr_set_i;
  logic [15:0] wr_data_i;
  logic        clear_status_i;
  logic        serial_poll_i;
  logic [15:0] rd_data_o;
  logic        srq_o;
  logic [15:0] d;
  int          err_count = 0;
  int          checks_done = 0;
  // set, condition, expected condition, expected event
  logic [3:0][15:0] rows [4] = '{
    '{16'h0000, 16'h8001, 16'h0001, 16'h0001},
    '{16'h0000, 16'h0100, 16'h0100, 16'h0101},
    '{16'h0001, 16'hFFFF, 16'h7FFF, 16'h7FFF},
    '{16'h0001, 16'h0000, 16'h0000, 16'h7FFF}};

  srm_top srm_top_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cond_i(cond_i),
    .std_evt_set_i(std_evt_set_i), .msg_avail_i(msg_avail_i), .rd_i(rd_i),
    .rd_sel_i(rd_sel_i), .rd_set_i(rd_set_i), .wr_i(wr_i), .wr_sel_i(wr_sel_i),
    .wr_set_i(wr_set_i), .wr_data_i(wr_data_i), .clear_status_i(clear_status_i),
    .serial_poll_i(serial_poll_i), .rd_data_o(rd_data_o), .srq_o(srq_o));

  srm_ctrl_model srm_ctrl_model_inst (.ref_clk_i(ref_clk_i), .data_i(rd_data_o),
    .rd_o(rd_i), .rsel_o(rd_sel_i), .rset_o(rd_set_i), .wr_o(wr_i),
    .wsel_o(wr_sel_i), .wset_o(wr_set_i), .wdata_o(wr_data_i),
    .cls_o(clear_status_i), .poll_o(serial_poll_i));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rc(input string n, input logic [2:0] s, input logic t,
                    input logic [15:0] e);
    logic [15:0] g;
    srm_ctrl_model_inst.rd(s, t, g);
    chk(n, e, g);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk_i = 1'h0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  initial
  begin
    #100000;
    err_count++;
    end_of_test();
  end

  initial
  begin
    rst_i = 1'h1;
    cond_i = 32'h00000000;
    std_evt_set_i = 8'h00;
    msg_avail_i = 1'h0;
    idle(3);
    rst_i <= 1'h0;
    rc("ena_rst", 3'h6, 1'h1, 16'h0000);
    rc("sre_rst", 3'h1, 1'h0, 16'h0000);
    rc("ese_rst", 3'h3, 1'h0, 16'h0000);
    chk("srq_rst", 16'h0000, {15'h0000, srq_o});
    foreach (rows[i])
    begin
      @(posedge ref_clk_i);
      cond_i <= rows[i][3][0] ? {rows[i][2], cond_i[15:0]} : {cond_i[31:16], rows[i][2]};
      idle(3);
      rc("cond", 3'h4, rows[i][3][0], rows[i][1]);
      rc("evt", 3'h5, rows[i][3][0], rows[i][0]);
      rc("evt_clr", 3'h5, rows[i][3][0], 16'h0000);
    end
    srm_ctrl_model_inst.wr(3'h6, 1'h0, 16'hFFFF);
    rc("ena", 3'h6, 1'h0, 16'h7FFF);
    srm_ctrl_model_inst.wr(3'h1, 1'h0, 16'hFFFF);
    rc("sre", 3'h1, 1'h0, 16'h00BF);
    srm_ctrl_model_inst.wr(3'h4, 1'h0, 16'hFFFF);
    srm_ctrl_model_inst.wr(3'h5, 1'h0, 16'hFFFF);
    rc("cond_wr", 3'h4, 1'h0, 16'h0100);
    rc("evt_wr", 3'h5, 1'h0, 16'h0000);
    @(posedge ref_clk_i);
    cond_i[15:0] <= 16'h0101;
    idle(4);
    chk("srq_set", 16'h0001, {15'h0000, srq_o});
    rc("stb", 3'h0, 1'h0, 16'h0048);
    srm_ctrl_model_inst.poll(d);
    chk("poll", 16'h0048, d);
    chk("srq_poll", 16'h0000, {15'h0000, srq_o});
    rc("stb_poll", 3'h0, 1'h0, 16'h0048);
    srm_ctrl_model_inst.cls();
    rc("stb_cls", 3'h0, 1'h0, 16'h0000);
    rc("evt_cls", 3'h5, 1'h0, 16'h0000);
    srm_ctrl_model_inst.wr(3'h3, 1'h0, 16'hFFFF);
    rc("ese", 3'h3, 1'h0, 16'h00FF);
    @(posedge ref_clk_i);
    std_evt_set_i <= 8'h21;
    @(posedge ref_clk_i);
    std_evt_set_i <= 8'h00;
    idle(2);
    rc("stb_std", 3'h0, 1'h0, 16'h0060);
    rc("std", 3'h2, 1'h0, 16'h0021);
    rc("std_clr", 3'h2, 1'h0, 16'h0000);
    msg_avail_i <= 1'h1;
    idle(2);
    rc("stb_msg", 3'h0, 1'h0, 16'h0050);
    rc("unused", 3'h7, 1'h0, 16'h0000);
    @(posedge ref_clk_i);
    cond_i[16] <= 1'h1;
    @(posedge ref_clk_i);
    cond_i[16] <= 1'h0;
    @(posedge ref_clk_i);
    cond_i[16] <= 1'h1;
    idle(3);
    rc("evt_hold", 3'h5, 1'h1, 16'h0001);
    @(posedge ref_clk_i);
    cond_i <= 32'h00000000;
    msg_avail_i <= 1'h0;
    rst_i <= 1'h1;
    idle(3);
    rst_i <= 1'h0;
    chk("srq_rst2", 16'h0000, {15'h0000, srq_o});
    rc("ena_rst2", 3'h6, 1'h0, 16'h0000);
    rc("sre_rst2", 3'h1, 1'h0, 16'h0000);
    rc("ese_rst2", 3'h3, 1'h0, 16'h0000);
    rc("stb_rst2", 3'h0, 1'h0, 16'h0000);
    end_of_test();
  end
endmodule

`default_nettype wire
